/* File: inc/ifp_pkg.sv */
package ifp_pkg;
    localparam int unsigned SRC_N     = 32;
    localparam int unsigned IDX_W     = 5;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned PRIO_REGS = 8;
    localparam int unsigned LANES     = 4;
    localparam int unsigned LANE_W    = 8;
    localparam int unsigned PRIO_LSB  = 2;
    localparam int unsigned PRIO_W    = 3;
    localparam int unsigned SUB_LSB   = 0;
    localparam int unsigned SUB_W     = 2;
    localparam int unsigned STAT_W    = 2;
    localparam int unsigned STAT_REQ  = 0;
    localparam int unsigned STAT_PROX = 1;

    localparam logic [ADDR_W-1:0] OFF_PROX   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAG   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ENA    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PRIO0  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h2c;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_TIMER  = 8'h38;
    localparam logic [ADDR_W-1:0] WORD_STEP  = 8'h04;

    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [31:0] PRIO_IMPL_MASK = 32'h1f1f_1f1f;
    localparam logic [2:0]  PRIO_OFF       = 3'h0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    function automatic logic [31:0] ifp_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : ifp_merge
endpackage : ifp_pkg

/* File: inc/ifp_reg_if.sv */
`timescale 1ns/100ps
interface ifp_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;

    modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input  wr_err, rd_data, rd_err);
    modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : ifp_reg_if

/* File: src/ifp_axil_slave.sv */
`timescale 1ns/100ps
module ifp_axil_slave (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [ifp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [ifp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    ifp_reg_if.slv                          regs
);
    import ifp_pkg::*;

    typedef struct packed {
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } ifp_axi_s;

    ifp_axi_s q;
    ifp_axi_s d;

    always_comb begin
        d             = q;
        s_axi_awready = !q.aw_held && !q.bvalid;
        s_axi_wready  = !q.w_held && !q.bvalid;
        s_axi_arready = !q.rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_held = 1'b1;
            d.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_held = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        // Write lands once address and data are both held
        regs.wr_en   = q.aw_held && q.w_held;
        regs.wr_addr = q.waddr;
        regs.wr_data = q.wdata;
        regs.wr_strb = q.wstrb;
        if (regs.wr_en) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = regs.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        regs.rd_en   = s_axi_arvalid && s_axi_arready;
        regs.rd_addr = s_axi_araddr;
        if (regs.rd_en) begin
            d.rvalid = 1'b1;
            d.rdata  = regs.rd_data;
            d.rresp  = regs.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp  = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata  = q.rdata;
    assign s_axi_rresp  = q.rresp;
endmodule : ifp_axil_slave

/* File: src/ifp_resolver.sv */
`timescale 1ns/100ps
module ifp_resolver #(
    parameter int unsigned NUM_SRC = 32,
    parameter int unsigned IDX_W   = 5
) (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic [NUM_SRC-1:0]      pend,
    input  wire logic [NUM_SRC-1:0][2:0] prio,
    input  wire logic [NUM_SRC-1:0][1:0] sub,
    output logic                         win_valid,
    output logic [IDX_W-1:0]             win_src,
    output logic [2:0]                   win_level,
    output logic [1:0]                   win_sub
);
    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] src;
        logic [2:0]       level;
        logic [1:0]       sub;
    } ifp_win_s;

    ifp_win_s q;
    ifp_win_s d;

    // Highest level, then highest subpriority, then lowest index
    always_comb begin
        d = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend[i] && (!d.valid || {prio[i], sub[i]} > {d.level, d.sub})) begin
                d.valid = 1'b1;
                d.src   = IDX_W'(i);
                d.level = prio[i];
                d.sub   = sub[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign win_valid = q.valid;
    assign win_src   = q.src;
    assign win_level = q.level;
    assign win_sub   = q.sub;
endmodule : ifp_resolver

/* File: src/ifp_ctrl.sv */
// Behaviour
// - An interrupt event loads the proximity timer from the reload register
// - A flag reads one after its source requested, zero otherwise; software may write
// - The flag register holds 32 flags, one per source, bits 31 to 0
// - An enable bit of one permits its source, zero blocks it
// - Priority codes 1..7 are levels; code zero disables the source (the code still lets its requests load the proximity timer)
// - Subpriority is the plain binary value of its 2-bit field
// - Top lane of a priority register: priority 28-26, subpriority 25-24
// - Lower lanes alike: 20-18 with 17-16, 12-10 for the next
// - Top three bits of each priority lane ignore writes and read zero
// - Every flag, enable, priority and reload bit clears at reset
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ifp_ctrl (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic [ifp_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ifp_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [ifp_pkg::SRC_N-1:0]   irq_req,
    output logic                             core_req_valid,
    output logic [ifp_pkg::IDX_W-1:0]        core_req_src,
    output logic [2:0]                       core_req_level,
    output logic [1:0]                       core_req_sub,
    output logic [31:0]                      proximity_timer_value,
    output logic                             irq
);
    import ifp_pkg::*;

    typedef struct packed {
        logic [31:0]                 reload;
        logic [SRC_N-1:0]            flag;
        logic [SRC_N-1:0]            enable;
        logic [PRIO_REGS-1:0][31:0]  prio;
        logic [STAT_W-1:0]           status;
        logic [STAT_W-1:0]           mask;
        logic [31:0]                 timer;
    } ifp_state_s;

    ifp_state_s               st_q;
    ifp_state_s               st_d;
    ifp_reg_if                regs ();
    logic [SRC_N-1:0][2:0]    src_prio;
    logic [SRC_N-1:0][1:0]    src_sub;
    logic [SRC_N-1:0]         active_vec;
    logic [SRC_N-1:0]         new_req;
    logic                     prox_evt;
    logic [STAT_W-1:0]        events;
    logic [31:0]              wr_word;
    logic                     rd_is_prio;

    ifp_axil_slave u_slave (
        .clk           (clk),
        .rst_b         (rst_b),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs.slv)
    );

    // Per-source fields out of the packed priority words
    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        assign src_prio[i] = st_q.prio[i / LANES][(i % LANES) * LANE_W + PRIO_LSB +: PRIO_W];
        assign src_sub[i]  = st_q.prio[i / LANES][(i % LANES) * LANE_W + SUB_LSB +: SUB_W];
        assign active_vec[i] = st_q.flag[i] && st_q.enable[i] && (src_prio[i] != PRIO_OFF);
    end

    ifp_resolver #(
        .NUM_SRC (SRC_N),
        .IDX_W   (IDX_W)
    ) u_resolver (
        .clk       (clk),
        .rst_b     (rst_b),
        .pend      (active_vec),
        .prio      (src_prio),
        .sub       (src_sub),
        .win_valid (core_req_valid),
        .win_src   (core_req_src),
        .win_level (core_req_level),
        .win_sub   (core_req_sub)
    );

    // Events: a fresh request, and a fresh request on an enabled source
    assign new_req  = irq_req & ~st_q.flag;
    assign prox_evt = |(new_req & st_q.enable);
    always_comb begin
        events            = '0;
        events[STAT_REQ]  = |new_req;
        events[STAT_PROX] = prox_evt;
    end

    always_comb begin
        st_d    = st_q;
        wr_word = RST_WORD;
        if (regs.wr_en) begin
            case (regs.wr_addr)
                OFF_PROX: begin
                    st_d.reload = ifp_merge(st_q.reload, regs.wr_data, regs.wr_strb);
                end
                OFF_FLAG: begin
                    st_d.flag = ifp_merge(st_q.flag, regs.wr_data, regs.wr_strb);
                end
                OFF_ENA: begin
                    st_d.enable = ifp_merge(st_q.enable, regs.wr_data, regs.wr_strb);
                end
                OFF_STAT: begin
                    wr_word     = ifp_merge(RST_WORD, regs.wr_data, regs.wr_strb);
                    st_d.status = st_q.status & ~wr_word[STAT_W-1:0];
                end
                OFF_MASK: begin
                    wr_word   = ifp_merge(RST_WORD, regs.wr_data, regs.wr_strb);
                    st_d.mask = wr_word[STAT_W-1:0];
                end
                default: begin
                    for (int k = 0; k < PRIO_REGS; k++) begin
                        if (regs.wr_addr == OFF_PRIO0 + ADDR_W'(k) * WORD_STEP) begin
                            st_d.prio[k] = ifp_merge(st_q.prio[k], regs.wr_data,
                                                     regs.wr_strb) & PRIO_IMPL_MASK;
                        end
                    end
                end
            endcase
        end
        st_d.flag   = st_d.flag | irq_req;
        st_d.status = st_d.status | events;
        if (prox_evt) begin
            st_d.timer = st_q.reload;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        regs.wr_err = 1'b1;
        case (regs.wr_addr)
            OFF_PROX, OFF_FLAG, OFF_ENA, OFF_STAT, OFF_MASK: begin
                regs.wr_err = 1'b0;
            end
            default: begin
                for (int k = 0; k < PRIO_REGS; k++) begin
                    if (regs.wr_addr == OFF_PRIO0 + ADDR_W'(k) * WORD_STEP) begin
                        regs.wr_err = 1'b0;
                    end
                end
            end
        endcase
    end

    always_comb begin
        regs.rd_data = RST_WORD;
        regs.rd_err  = 1'b0;
        rd_is_prio   = 1'b0;
        case (regs.rd_addr)
            OFF_PROX:   regs.rd_data = st_q.reload;
            OFF_FLAG:   regs.rd_data = st_q.flag;
            OFF_ENA:    regs.rd_data = st_q.enable;
            OFF_STAT:   regs.rd_data[STAT_W-1:0] = st_q.status;
            OFF_MASK:   regs.rd_data[STAT_W-1:0] = st_q.mask;
            OFF_ACTIVE: regs.rd_data = active_vec;
            OFF_TIMER:  regs.rd_data = st_q.timer;
            default: begin
                regs.rd_err = 1'b1;
                for (int k = 0; k < PRIO_REGS; k++) begin
                    if (regs.rd_addr == OFF_PRIO0 + ADDR_W'(k) * WORD_STEP) begin
                        regs.rd_data = st_q.prio[k];
                        regs.rd_err  = 1'b0;
                        rd_is_prio   = 1'b1;
                    end
                end
            end
        endcase
    end

    assign proximity_timer_value = st_q.timer;
    assign irq                   = |(st_q.status & st_q.mask);

    property p_reload;
        @(posedge clk) disable iff (!rst_b)
        prox_evt |=> st_q.timer == $past(st_q.reload);
    endproperty
    a_reload: assert property (p_reload) else $error("timer not loaded");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_b)
        (|irq_req) |=> (st_q.flag & $past(irq_req)) == $past(irq_req);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");

    property p_flag_read;
        @(posedge clk) disable iff (!rst_b)
        (regs.rd_en && regs.rd_addr == OFF_FLAG) |=> s_axi_rvalid
            && s_axi_rdata == $past(st_q.flag);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag word bad");

    property p_enable_gate;
        @(posedge clk) disable iff (!rst_b)
        core_req_valid |-> ($past(st_q.enable) & (SRC_N'(1) << core_req_src)) != '0;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("disabled source");

    property p_level_nonzero;
        @(posedge clk) disable iff (!rst_b)
        core_req_valid |-> core_req_level != PRIO_OFF;
    endproperty
    a_level_nonzero: assert property (p_level_nonzero) else $error("level zero");

    property p_lane3;
        @(posedge clk) disable iff (!rst_b)
        (regs.wr_en && regs.wr_addr == OFF_PRIO0 && regs.wr_strb[3])
            |=> src_prio[3] == $past(regs.wr_data[28:26])
             && src_sub[3] == $past(regs.wr_data[25:24]);
    endproperty
    a_lane3: assert property (p_lane3) else $error("lane3 field");

    property p_lane12;
        @(posedge clk) disable iff (!rst_b)
        (regs.wr_en && regs.wr_addr == OFF_PRIO0 && regs.wr_strb[2] && regs.wr_strb[1])
            |=> src_prio[2] == $past(regs.wr_data[20:18])
             && src_sub[2] == $past(regs.wr_data[17:16])
             && src_prio[1] == $past(regs.wr_data[12:10]);
    endproperty
    a_lane12: assert property (p_lane12) else $error("lane2 or lane1 field");

    property p_unimpl;
        @(posedge clk) disable iff (!rst_b)
        (regs.rd_en && rd_is_prio) |=> (s_axi_rdata & ~PRIO_IMPL_MASK) == RST_WORD;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");

    property p_reset;
        @(posedge clk) $rose(rst_b) |-> st_q == '0 && !core_req_valid;
    endproperty
    a_reset: assert property (p_reset) else $error("state not cleared");

    property p_present;
        @(posedge clk) disable iff (!rst_b)
        core_req_valid |-> $past(|active_vec)
            && ($past(st_q.flag) & (SRC_N'(1) << core_req_src)) != '0;
    endproperty
    a_present: assert property (p_present) else $error("unflagged source");

    property p_irq_ack;
        @(posedge clk) disable iff (!rst_b)
        (regs.wr_en && regs.wr_addr == OFF_STAT && regs.wr_strb[0]
            && regs.wr_data[STAT_REQ] && !events[STAT_REQ])
            |=> !st_q.status[STAT_REQ];
    endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("status not cleared");

    c_core_top: cover property (@(posedge clk) disable iff (!rst_b)
        core_req_valid && core_req_level == 3'h7);
    c_prox: cover property (@(posedge clk) disable iff (!rst_b) prox_evt);
    c_irq: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
endmodule : ifp_ctrl

/* File: tb/ifp_core_model.sv */
`timescale 1ns/100ps
module ifp_core_model
    import ifp_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       req_valid,
    input  wire logic [ifp_pkg::IDX_W-1:0]  req_src,
    input  wire logic [2:0]                 req_level,
    input  wire logic [1:0]                 req_sub,
    input  wire logic                       irq,
    output logic      [11:0]                seen_q
);
    // Core latches the presented request every cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_q <= '0;
        end else begin
            seen_q <= {req_valid, req_src, req_level, req_sub, irq};
        end
    end
endmodule : ifp_core_model

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
    import ifp_pkg::*;
    logic [31:0] s_axi_wdata, s_axi_rdata, proximity_timer_value, irq_req, seed, r, v;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, core_req_sub;
    logic        clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, core_req_valid, irq;
    logic [4:0]  core_req_src;
    logic [2:0]  core_req_level;
    logic [11:0] seen;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [11:0] cq[$];
    logic [31:0] tq[$];
    logic        look;
    int          fails = 0, comparisons = 0, cyc = 0;

    ifp_ctrl i_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_req, .core_req_valid, .core_req_src,
        .core_req_level, .core_req_sub, .proximity_timer_value, .irq);
    ifp_core_model i_core (.clk, .rst_b, .req_valid(core_req_valid), .req_src(core_req_src),
        .req_level(core_req_level), .req_sub(core_req_sub), .irq, .seen_q(seen));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
        end
    endtask : chk_rd

    task automatic chk_b(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t bresp %h expected %h", $time, g, e);
        end
    endtask : chk_b

    task automatic chk_core(input logic [11:0] g, input logic [11:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t core %h expected %h", $time, g, e);
        end
    endtask : chk_core

    task automatic chk_tmr(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t timer %h expected %h", $time, g, e);
        end
    endtask : chk_tmr

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e);
        logic ta, tw, tk;
        tk = 1'b0;
        bq.push_back(e);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!tk) begin
            @(negedge clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tk = s_axi_bvalid;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ta, tk;
        tk = 1'b0;
        rq.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (!tk) begin
            @(negedge clk);
            ta = s_axi_arvalid & s_axi_arready;
            tk = s_axi_rvalid;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
    endtask : rd

    // Pulses requests, then flags the cycle where core and timer are due
    task automatic ev(input logic [31:0] q, input logic [11:0] e, input logic [31:0] t);
        cq.push_back(e);
        tq.push_back(t);
        irq_req <= q;
        @(posedge clk);
        irq_req <= '0;
        repeat (2) @(posedge clk);
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : ev

    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk_rd({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk_b(s_axi_bresp, bq.pop_front());
        if (look) begin
            chk_core(seen, cq.pop_front());
            chk_tmr(proximity_timer_value, tq.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        seed = 32'he19d73df;
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, look} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, irq_req} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 'h38; a += 4) rd(a[7:0], '0);
        rd(8'h3c, {RESP_SLVERR, 32'h0});
        rd(8'h02, {RESP_SLVERR, 32'h0});
        wr(OFF_ACTIVE, 32'h1, 4'hf, RESP_SLVERR);
        for (int a = 0; a < 12; a += 4) begin
            r = $random(seed);
            wr(a[7:0], r, 4'hf, RESP_OKAY);
            rd(a[7:0], {RESP_OKAY, r});
            wr(a[7:0], '0, 4'hf, RESP_OKAY);
            rd(a[7:0], {RESP_OKAY, 32'h0});
        end
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            wr(OFF_PRIO0 + 8'(4 * k), v, 4'hf, RESP_OKAY);
            rd(OFF_PRIO0 + 8'(4 * k), {RESP_OKAY, v & PRIO_IMPL_MASK});
        end
        wr(OFF_PRIO0 + 8'h1c, 32'hffff_ffff, 4'h1, RESP_OKAY);
        rd(OFF_PRIO0 + 8'h1c, {RESP_OKAY, {v[31:8], 8'hff} & PRIO_IMPL_MASK});
        r = $random(seed);
        wr(OFF_PROX, r, 4'hf, RESP_OKAY);
        wr(OFF_PRIO0 + 8'h04, 32'h000e_0d00, 4'hf, RESP_OKAY);
        wr(OFF_PRIO0 + 8'h1c, 32'h1f00_0000, 4'hf, RESP_OKAY);
        wr(OFF_ENA, 32'h0000_0070, 4'hf, RESP_OKAY);
        wr(OFF_MASK, 32'h3, 4'hf, RESP_OKAY);
        ev(32'h10, {1'b0, 5'd0, 3'd0, 2'd0, 1'b1}, r);
        rd(OFF_TIMER, {RESP_OKAY, r});
        ev(32'h20, {1'b1, 5'd5, 3'd3, 2'd1, 1'b1}, r);
        rd(OFF_FLAG, {RESP_OKAY, 32'h30});
        ev(32'h40, {1'b1, 5'd6, 3'd3, 2'd2, 1'b1}, r);
        wr(OFF_ENA, 32'h8000_0020, 4'hf, RESP_OKAY);
        wr(OFF_PROX, ~r, 4'hf, RESP_OKAY);
        ev(32'h0, {1'b1, 5'd5, 3'd3, 2'd1, 1'b1}, r);
        ev(32'h8000_0000, {1'b1, 5'd31, 3'd7, 2'd3, 1'b1}, ~r);
        wr(OFF_MASK, 32'h0, 4'hf, RESP_OKAY);
        ev(32'h0, {1'b1, 5'd31, 3'd7, 2'd3, 1'b0}, ~r);
        wr(OFF_MASK, 32'h3, 4'hf, RESP_OKAY);
        rd(OFF_STAT, {RESP_OKAY, 32'h3});
        wr(OFF_STAT, 32'h3, 4'hf, RESP_OKAY);
        wr(OFF_FLAG, 32'h0, 4'hf, RESP_OKAY);
        ev(32'h0, 12'h0, ~r);
        complete_run();
    end
endmodule : tb
